/* dv/mpc_checker.sv */
`timescale 1ns/10ps
module mpc_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  base_pulse_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_acc;
  assign wr_acc = wb_ack_o && wb_we_i && wb_sel_i[0];
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  a_byte_only: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("wide data");
  a_high_narrow: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i inside {6'h08, 6'h10, 6'h18, 6'h20, 6'h28} |-> wb_dat_o[7:2] == 6'h0)
    else $error("high byte too wide");
  a_stop_quiet: assert property (wr_acc && wb_adr_i == 6'h00 && !wb_dat_i[3]
    |-> ##2 base_pulse_o == 3'h0) else $error("pulse after stop");
  a_mask_off: assert property (wr_acc && wb_adr_i == 6'h30 && wb_dat_i[3:0] == 4'h0
    |-> ##2 !irq_o) else $error("irq while masked");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && base_pulse_o == 3'h0)
    else $error("outputs after reset");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_irq: cover property ($rose(irq_o));
  c_pulse: cover property (base_pulse_o != 3'h0);
endmodule // mpc_checker

bind mpc_pwm_counter mpc_checker i_mpc_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .base_pulse_o, .irq_o);

/* dv/mpc_gate_model.sv */
`timescale 1ns/10ps
module mpc_gate_model (
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic [2:0]  pulse_i,
  output logic [2:0][15:0] on_cnt_o
);
  // gate stage integrates each phase's on-time between clears
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 3; c++) begin
      if (clr_i) on_cnt_o[c] <= 16'h0;
      else on_cnt_o[c] <= on_cnt_o[c] + {15'h0, pulse_i[c]};
    end
  end
endmodule // mpc_gate_model

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0;
  logic [3:0]       sel = 4'h0;
  logic [5:0]       adr = 6'h00;
  logic [31:0]      wdat = 32'h0, rdat;
  logic             ack, irq;
  logic [2:0]       pulse;
  logic [2:0][15:0] on_cnt;
  logic [9:0]       nv [4], act_v [4];
  logic [7:0]       q, v;
  int               n_errors = 0, samples_checked = 0, seed = 32'h2d020e44;

  mpc_pwm_counter i_mpc_pwm_counter (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .base_pulse_o(pulse), .irq_o(irq));
  mpc_gate_model i_mpc_gate_model (.clk_i(clk_i), .clr_i(clr), .pulse_i(pulse),
    .on_cnt_o(on_cnt));

  initial forever #50 clk_i = ~clk_i;

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int t;
    {cyc, stb, we, sel, adr, wdat} <= {2'h3, w, 4'h1, a, 24'h0, d};
    for (t = 0; t < 20; t++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat[7:0];
    {cyc, stb, we, sel} <= 7'h0;
    @(posedge clk_i);
    if (t == 20) begin
      n_errors++;
      end_of_test;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    chk({8'h0, q}, {8'h0, e});
  endtask
  function automatic logic [5:0] ofs(input int c, input logic hi);
    if (c == 3) return hi ? mpc_pkg::OFS_PER_HI : mpc_pkg::OFS_PER_LO;
    return hi ? mpc_pkg::OFS_DUTY_HI[c] : mpc_pkg::OFS_DUTY_LO[c];
  endfunction
  // clocks high over two periods of the edge-aligned counter
  function automatic logic [15:0] on_time(input logic [9:0] d, p, input int cs);
    return 16'(d > p ? p + 10'h1 : d) << (cs + 1);
  endfunction
  function automatic logic [7:0] stat_exp(input int al, sel);
    return (al > 1 && sel > 0) ? 8'h0f : 8'h08;
  endfunction

  task automatic pwm(input int cs, input logic ld);
    nv[3] = 10'(12 + ($random(seed) & 15));
    for (int c = 0; c < 3; c++) nv[c] = 10'(2 + ($random(seed) & 7));
    if (cs == 0) nv[0] = 10'h0;
    if (cs == 0) nv[2] = nv[3] + 10'h1;
    for (int c = 0; c < 4; c++) begin
      wr(ofs(c, 1'b1), {6'($random(seed)), nv[c][9:8]});
      wr(ofs(c, 1'b0), nv[c][7:0]);
      rd(ofs(c, 1'b1), {6'h0, nv[c][9:8]});
      rd(ofs(c, 1'b0), nv[c][7:0]);
    end
    if (ld) begin
      act_v = nv;
      wr(mpc_pkg::OFS_CTRL, {2'h0, 2'(cs), 4'h9});
      q = 8'h01;
      for (int t = 0; t < 100 && q[0] !== 1'b0; t++) bus(1'b0, mpc_pkg::OFS_CTRL, 8'h0);
      chk({8'h0, q}, {10'h0, 2'(cs), 4'h8});
      if (q[0] !== 1'b0) end_of_test;
    end
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat ((int'(act_v[3]) + 1) << (cs + 1)) @(posedge clk_i);
    @(negedge clk_i);
    for (int c = 0; c < 3; c++) chk(on_cnt[c], on_time(act_v[c], act_v[3], cs));
    @(posedge clk_i);
    wr(mpc_pkg::OFS_CNT_LO, 8'hff);
    bus(1'b0, mpc_pkg::OFS_CNT_LO, 8'h0);
    chk({15'h0, (q <= act_v[3][7:0])}, 16'h1);
    rd(mpc_pkg::OFS_CNT_HI, 8'h0);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 64; a += 4) rd(6'(a), 8'h0);
    wr(6'h3c, 8'hff);
    rd(6'h3c, 8'h0);
    for (int cs = 0; cs < 4; cs++) pwm(cs, 1'b1);
    pwm(3, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(mpc_pkg::OFS_MASK, 8'h00);
      wr(mpc_pkg::OFS_CTRL, {2'(i), 2'h0, 1'b1, 2'(3 - i), 1'b0});
      repeat (4 * (int'(act_v[3]) + 1)) @(posedge clk_i);
      wr(mpc_pkg::OFS_CTRL, {2'(i), 6'h00});
      repeat (2) @(posedge clk_i);
      chk({13'h0, pulse}, 16'h0);
      bus(1'b0, mpc_pkg::OFS_CNT_LO, 8'h0);
      v = q;
      rd(mpc_pkg::OFS_CNT_LO, v);
      rd(mpc_pkg::OFS_STAT, stat_exp(i, 3 - i));
      chk({15'h0, irq}, 16'h0);
      wr(mpc_pkg::OFS_MASK, 8'h0f);
      @(posedge clk_i);
      chk({15'h0, irq}, 16'h1);
      wr(mpc_pkg::OFS_STAT, 8'h0f);
      rd(mpc_pkg::OFS_STAT, 8'h00);
      chk({15'h0, irq}, 16'h0);
    end
    end_of_test;
  end
endmodule // testbench

/* hw/mpc_pkg.sv */
// Behaviour
// - one pwm generator; counter, period and duty all ten bits; period and duty software programmable
// - three channels, each with a ten-bit duty split into low and high bytes
// - duty high bytes read zero in bits 7 to 2
// - low and high period bytes form one ten-bit period shared by all channels
// - each channel output is active for its duty portion of every period
// - the live ten-bit counter is readable through two counter bytes
// - control bits 7..6: 0x edge, 10 centre mode 1, 11 centre mode 2
// - control bits 5..4 divide the counter clock by 1, 2, 4 or 8
// - lowest pwm rate scales with base clock over divisor and full period
// - control bit 3 runs the counter; zero stops it and turns pwm off
// - control bits 2..1 pick centre duty interrupt: off, up, down, both
// - with load bit zero, shadow period and duties never reach active registers
// - with load bit one, shadow period and duties are copied into the active registers at next underflow, or peak in centre mode 2
// - load bit clears itself on the clock cycle after the load
// - counter view bytes are read-only, reset to zero, bits 7..0 and 9..8
// - period high byte holds bits 9..8, upper bits read zero, reset zero
package mpc_pkg;
  localparam int unsigned          VAL_W      = 10;
  localparam int unsigned          CH_N       = 3;
  localparam int unsigned          ADR_W      = 6;
  localparam int unsigned          DIV_W      = 3;
  localparam int unsigned          STAT_W     = 4;
  localparam int unsigned          HI_W       = 2;
  localparam logic [ADR_W-1:0]     OFS_CTRL   = 6'h00;
  localparam logic [ADR_W-1:0]     OFS_DUTY_LO [CH_N] = '{6'h04, 6'h0c, 6'h14};
  localparam logic [ADR_W-1:0]     OFS_DUTY_HI [CH_N] = '{6'h08, 6'h10, 6'h18};
  localparam logic [ADR_W-1:0]     OFS_PER_LO = 6'h1c;
  localparam logic [ADR_W-1:0]     OFS_PER_HI = 6'h20;
  localparam logic [ADR_W-1:0]     OFS_CNT_LO = 6'h24;
  localparam logic [ADR_W-1:0]     OFS_CNT_HI = 6'h28;
  localparam logic [ADR_W-1:0]     OFS_STAT   = 6'h2c;
  localparam logic [ADR_W-1:0]     OFS_MASK   = 6'h30;
  localparam logic [1:0]           ALIGN_CTR1 = 2'h2;
  localparam logic [1:0]           ALIGN_CTR2 = 2'h3;
  localparam int unsigned          IRQSEL_UP  = 0;
  localparam int unsigned          IRQSEL_DN  = 1;
  localparam int unsigned          STAT_UFLOW = 3;
  localparam logic [7:0]           CTRL_RST   = 8'h00;
  localparam logic [VAL_W-1:0]     VAL_RST    = 10'h000;
  localparam logic [VAL_W-1:0]     VAL_ONE    = 10'h001;
  localparam logic [STAT_W-1:0]    STAT_RST   = 4'h0;

  typedef struct packed {
    logic [1:0] align;
    logic [1:0] clk_sel;
    logic       run;
    logic [1:0] irq_sel;
    logic       load;
  } mpc_ctrl_s;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } mpc_dir_e;
endpackage

/* hw/mpc_pwm_counter.sv */
`timescale 1ns/10ps
module mpc_pwm_counter (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [mpc_pkg::ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  output logic      [mpc_pkg::CH_N-1:0]        base_pulse_o,
  output logic                                 irq_o
);
  typedef logic [mpc_pkg::VAL_W-1:0] mpc_val_t;

  mpc_pkg::mpc_ctrl_s            ctrl, next_ctrl;
  mpc_val_t                      duty_sh  [mpc_pkg::CH_N];
  mpc_val_t                      next_duty_sh [mpc_pkg::CH_N];
  mpc_val_t                      duty_act [mpc_pkg::CH_N];
  mpc_val_t                      next_duty_act [mpc_pkg::CH_N];
  mpc_val_t                      per_sh, next_per_sh, per_act, next_per_act;
  mpc_val_t                      cnt, next_cnt;
  mpc_pkg::mpc_dir_e             dir, next_dir;
  logic [mpc_pkg::DIV_W-1:0]     div_cnt, next_div_cnt;
  logic                          load_done, next_load_done;
  logic [mpc_pkg::STAT_W-1:0]    stat, next_stat, mask, next_mask;
  logic [mpc_pkg::CH_N-1:0]      next_pulse;
  logic                          next_irq, next_ack;
  logic [31:0]                   next_rdat;

  // divide-by-1/2/4/8 terminal count
  function automatic logic [mpc_pkg::DIV_W-1:0] div_max(input logic [1:0] sel);
    div_max = mpc_pkg::DIV_W'((1 << sel) - 1);
  endfunction

  // place a ten-bit value on the low or high byte view
  function automatic logic [7:0] lo_byte(input mpc_val_t v);
    lo_byte = v[7:0];
  endfunction

  function automatic logic [7:0] hi_byte(input mpc_val_t v);
    hi_byte = {6'h00, v[mpc_pkg::VAL_W-1:8]};
  endfunction

  always_comb begin
    logic                          req;
    logic                          wr;
    logic                          tick;
    logic                          centre;
    logic                          uflow;
    logic                          peak;
    logic [mpc_pkg::STAT_W-1:0]    ev;
    logic [mpc_pkg::STAT_W-1:0]    clr;
    logic [7:0]                    rd;
    req            = wb_cyc_i & wb_stb_i;
    wr             = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    tick           = 1'b0;
    centre         = ctrl.align[1];
    uflow          = 1'b0;
    peak           = 1'b0;
    ev             = '0;
    clr            = '0;
    rd             = 8'h00;
    next_ctrl      = ctrl;
    next_duty_sh   = duty_sh;
    next_duty_act  = duty_act;
    next_per_sh    = per_sh;
    next_per_act   = per_act;
    next_cnt       = cnt;
    next_dir       = dir;
    next_div_cnt   = div_cnt;
    next_load_done = 1'b0;
    next_mask      = mask;

    // register writes take effect at the edge where ack is high
    if (wr) begin
      if (wb_adr_i == mpc_pkg::OFS_CTRL)
        next_ctrl = mpc_pkg::mpc_ctrl_s'(wb_dat_i[7:0]);
      for (int i = 0; i < mpc_pkg::CH_N; i++) begin
        if (wb_adr_i == mpc_pkg::OFS_DUTY_LO[i])
          next_duty_sh[i][7:0] = wb_dat_i[7:0];
        if (wb_adr_i == mpc_pkg::OFS_DUTY_HI[i])
          next_duty_sh[i][mpc_pkg::VAL_W-1:8] = wb_dat_i[mpc_pkg::HI_W-1:0];
      end
      if (wb_adr_i == mpc_pkg::OFS_PER_LO)
        next_per_sh[7:0] = wb_dat_i[7:0];
      if (wb_adr_i == mpc_pkg::OFS_PER_HI)
        next_per_sh[mpc_pkg::VAL_W-1:8] = wb_dat_i[mpc_pkg::HI_W-1:0];
      if (wb_adr_i == mpc_pkg::OFS_STAT)
        clr = wb_dat_i[mpc_pkg::STAT_W-1:0];
      if (wb_adr_i == mpc_pkg::OFS_MASK)
        next_mask = wb_dat_i[mpc_pkg::STAT_W-1:0];
    end

    // hardware clears the load bit one cycle after the transfer, unless rewritten
    if (load_done && !(wr && wb_adr_i == mpc_pkg::OFS_CTRL))
      next_ctrl.load = 1'b0;

    // prescaler; held in reset while the counter is off
    if (!ctrl.run) begin
      next_div_cnt = '0;
    end else if (div_cnt >= div_max(ctrl.clk_sel)) begin
      next_div_cnt = '0;
      tick         = 1'b1;
    end else begin
      next_div_cnt = div_cnt + 1'b1;
    end

    if (tick) begin
      if (!centre) begin
        next_dir = mpc_pkg::DIR_UP;
        if (cnt >= per_act) begin
          next_cnt = mpc_pkg::VAL_RST;
          uflow    = 1'b1;
        end else begin
          next_cnt = cnt + mpc_pkg::VAL_ONE;
        end
      end else begin
        unique case (dir)
          mpc_pkg::DIR_UP: begin
            if (cnt >= per_act) begin
              peak     = 1'b1;
              next_dir = mpc_pkg::DIR_DOWN;
              next_cnt = (cnt == mpc_pkg::VAL_RST) ? cnt : cnt - mpc_pkg::VAL_ONE;
            end else begin
              next_cnt = cnt + mpc_pkg::VAL_ONE;
            end
          end
          mpc_pkg::DIR_DOWN: begin
            if (cnt == mpc_pkg::VAL_RST) begin
              uflow    = 1'b1;
              next_dir = mpc_pkg::DIR_UP;
              next_cnt = (per_act == mpc_pkg::VAL_RST) ? cnt : mpc_pkg::VAL_ONE;
            end else begin
              next_cnt = cnt - mpc_pkg::VAL_ONE;
            end
          end
          default: begin
            next_dir = mpc_pkg::DIR_UP;
          end
        endcase
        // centre duty interrupt on the chosen direction
        for (int i = 0; i < mpc_pkg::CH_N; i++) begin
          if (cnt == duty_act[i]) begin
            if (dir == mpc_pkg::DIR_UP && ctrl.irq_sel[mpc_pkg::IRQSEL_UP])
              ev[i] = 1'b1;
            if (dir == mpc_pkg::DIR_DOWN && ctrl.irq_sel[mpc_pkg::IRQSEL_DN])
              ev[i] = 1'b1;
          end
        end
      end
      ev[mpc_pkg::STAT_UFLOW] = uflow;
    end

    // deferred load: underflow always, the peak as well in centre mode 2
    if (ctrl.load && (uflow || (peak && ctrl.align == mpc_pkg::ALIGN_CTR2))) begin
      next_per_act   = per_sh;
      next_duty_act  = duty_sh;
      next_load_done = 1'b1;
    end

    // sticky status: a new event wins over a clear in the same cycle
    next_stat = (stat & ~clr) | ev;
    next_irq  = |(next_stat & next_mask);

    for (int i = 0; i < mpc_pkg::CH_N; i++)
      next_pulse[i] = next_ctrl.run & (next_cnt < next_duty_act[i]);

    unique case (wb_adr_i)
      mpc_pkg::OFS_CTRL:   rd = ctrl;
      mpc_pkg::OFS_PER_LO: rd = lo_byte(per_sh);
      mpc_pkg::OFS_PER_HI: rd = hi_byte(per_sh);
      mpc_pkg::OFS_CNT_LO: rd = lo_byte(cnt);
      mpc_pkg::OFS_CNT_HI: rd = hi_byte(cnt);
      mpc_pkg::OFS_STAT:   rd = {4'h0, stat};
      mpc_pkg::OFS_MASK:   rd = {4'h0, mask};
      default:             rd = 8'h00;
    endcase
    for (int i = 0; i < mpc_pkg::CH_N; i++) begin
      if (wb_adr_i == mpc_pkg::OFS_DUTY_LO[i])
        rd = lo_byte(duty_sh[i]);
      if (wb_adr_i == mpc_pkg::OFS_DUTY_HI[i])
        rd = hi_byte(duty_sh[i]);
    end

    next_ack  = req & ~wb_ack_o;
    next_rdat = (req && !wb_ack_o && !wb_we_i) ? {24'h000000, rd} : 32'h00000000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl         <= mpc_pkg::mpc_ctrl_s'(mpc_pkg::CTRL_RST);
      per_sh       <= mpc_pkg::VAL_RST;
      per_act      <= mpc_pkg::VAL_RST;
      cnt          <= mpc_pkg::VAL_RST;
      dir          <= mpc_pkg::DIR_UP;
      div_cnt      <= '0;
      load_done    <= 1'b0;
      stat         <= mpc_pkg::STAT_RST;
      mask         <= mpc_pkg::STAT_RST;
      base_pulse_o <= '0;
      irq_o        <= 1'b0;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h00000000;
      for (int i = 0; i < mpc_pkg::CH_N; i++) begin
        duty_sh[i]  <= mpc_pkg::VAL_RST;
        duty_act[i] <= mpc_pkg::VAL_RST;
      end
    end else begin
      ctrl         <= next_ctrl;
      per_sh       <= next_per_sh;
      per_act      <= next_per_act;
      cnt          <= next_cnt;
      dir          <= next_dir;
      div_cnt      <= next_div_cnt;
      load_done    <= next_load_done;
      stat         <= next_stat;
      mask         <= next_mask;
      base_pulse_o <= next_pulse;
      irq_o        <= next_irq;
      wb_ack_o     <= next_ack;
      wb_dat_o     <= next_rdat;
      duty_sh      <= next_duty_sh;
      duty_act     <= next_duty_act;
    end
  end
endmodule // mpc_pwm_counter
